// ### core/alarm_defines.vh
// Contract
// - Any alarm blinks indicator, drives alarm output if assigned
// - Selected alarm types disable motor current
// - Alarms halt motion and sequence execution
// - Repeating blink cycle, count per alarm
// - Query returns active alarm code
// - Clear by command, reset, or power
// - Position range alarm 32h, one blink
// - Stack exhausted raises 90h
// - Missing subroutine raises 94h
// - Overflow 98h, divide by zero 9Ah
// - Parameter out of range raises 99h
// - Counter write during motion raises 9Dh
// - Missing user variable raises 9Eh
// - Forbidden parameter write raises 9Fh
// - Incompatible motion start raises A0h
// - User alarm command raises E0h
// - End-wait timeout raises 10h, four blinks
// - Done source: internal window or driver
// - Both limits active raises 60h, seven
`ifndef ALARM_DEFINES_VH
`define ALARM_DEFINES_VH
`define CODE_POS_RANGE    8'h32
`define CODE_STACK        8'h90
`define CODE_SEQ_REF      8'h94
`define CODE_CALC_OVF     8'h98
`define CODE_PARAM_RANGE  8'h99
`define CODE_ZERO_DIV     8'h9A
`define CODE_PC_WRITE     8'h9D
`define CODE_VAR_REF      8'h9E
`define CODE_PARAM_WRITE  8'h9F
`define CODE_MOTION_BUSY  8'hA0
`define CODE_USER         8'hE0
`define CODE_END_TIMEOUT  8'h10
`define CODE_LS_LOGIC     8'h60
`define CODE_NONE         8'h00
`define BLINKS_ONE        4'h1
`define BLINKS_FOUR       4'h4
`define BLINKS_SEVEN      4'h7
`define BLINK_ON_MS       200
`define BLINK_OFF_MS      200
`define BLINK_GAP_MS      1200
`define CLK_KHZ           125000
`define MS_TICK_CYCLES    (`CLK_KHZ)
`define SOURCE_COUNT      13
`endif

// ### core/motion_alarm_handler.v
`timescale 1ns/10ps
`include "alarm_defines.vh"
module motion_alarm_handler #(
	parameter MS_TICK      = `MS_TICK_CYCLES,
	parameter BLINK_ON     = `BLINK_ON_MS,
	parameter BLINK_OFF    = `BLINK_OFF_MS,
	parameter BLINK_GAP    = `BLINK_GAP_MS,
	// One bit per detector index; a set bit cuts motor current for that alarm
	parameter [12:0] CURRENT_OFF_MASK = 13'h1000
) (
	// Clock and reset
	input  wire        sys_clk_in,
	input  wire        srst_in,
	// Fault reports from the sequence and motion engines, same clock
	input  wire        pos_range_err_in,
	input  wire        stack_overflow_in,
	input  wire        seq_ref_err_in,
	input  wire        calc_overflow_in,
	input  wire        param_range_err_in,
	input  wire        zero_div_in,
	input  wire        pc_write_in,
	input  wire        var_ref_err_in,
	input  wire        param_write_err_in,
	input  wire        motion_start_in,
	input  wire        motion_busy_in,
	input  wire        user_alarm_cmd_in,
	// End-wait timing and its done sources
	input  wire        wait_motion_finish_in,
	input  wire        home_seek_in,
	input  wire        drive_done_select_in,
	input  wire        done_range_window_in,
	input  wire        driver_end_in,
	input  wire [31:0] motion_end_timeout_in,
	// Limit switch pins, asynchronous to the clock
	input  wire        limit_pos_in,
	input  wire        limit_neg_in,
	// Host configuration and commands
	input  wire        alarm_out_assigned_in,
	input  wire        alarm_clear_cmd_in,
	input  wire        reset_cmd_in,
	input  wire        alarm_code_query_in,
	// Alarm reporting
	output reg  [7:0]  alarm_code_out,
	output reg         alarm_code_valid_out,
	output wire        alarm_active_out,
	output wire        alarm_output_out,
	output reg         alarm_led_out,
	output wire        halt_out,
	output wire        current_off_out
);
	// One-hot blink sequencer states
	localparam ST_IDLE = 3'b001;
	localparam ST_ON   = 3'b010;
	localparam ST_OFF  = 3'b100;

	// Code table indexed by detector position; earlier entries win
	// Limits and timeout come first since they concern the mechanism itself
	function [7:0] code_of;
		input integer idx;
		begin
			case (idx)
			0:       code_of = `CODE_LS_LOGIC;
			1:       code_of = `CODE_END_TIMEOUT;
			2:       code_of = `CODE_POS_RANGE;
			3:       code_of = `CODE_STACK;
			4:       code_of = `CODE_SEQ_REF;
			5:       code_of = `CODE_CALC_OVF;
			6:       code_of = `CODE_PARAM_RANGE;
			7:       code_of = `CODE_ZERO_DIV;
			8:       code_of = `CODE_PC_WRITE;
			9:       code_of = `CODE_VAR_REF;
			10:      code_of = `CODE_PARAM_WRITE;
			11:      code_of = `CODE_MOTION_BUSY;
			12:      code_of = `CODE_USER;
			default: code_of = `CODE_NONE;
			endcase
		end
	endfunction

	// Blink count per latched code
	// Codes not listed blink once
	function [3:0] blinks_of;
		input [7:0] code;
		begin
			case (code)
			`CODE_LS_LOGIC:    blinks_of = `BLINKS_SEVEN;
			`CODE_END_TIMEOUT: blinks_of = `BLINKS_FOUR;
			default:           blinks_of = `BLINKS_ONE;
			endcase
		end
	endfunction

	// Limit pins come from outside: three stages, change taken when 2 and 3 agree
	// Both pins share one synchroniser shape, so a generate loop builds them
	wire [1:0] lim_raw = {limit_neg_in, limit_pos_in};
	wire [1:0] lim_ok;
	genvar     g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : lim_sync
			reg [2:0] sync_q;
			reg       level_q;
			always @(posedge sys_clk_in) begin
				if (srst_in) begin
					sync_q  <= 3'h0;
					level_q <= 1'b0;
				end else begin
					sync_q <= {sync_q[1:0], lim_raw[g]};
					// Disagreeing stages mean the pin is still settling: keep the old level
					if (sync_q[1] == sync_q[2])
						level_q <= sync_q[2];
				end
			end
			assign lim_ok[g] = level_q;
		end
	endgenerate

	// Motion done source select
	// Selection is read live, so changing it mid-wait swaps the source at once
	wire motion_done = drive_done_select_in ? driver_end_in : done_range_window_in;

	// End-wait timer runs while waiting and not yet done
	// A zero timeout alarms on the first waiting cycle that is not yet done
	reg  [31:0] wait_cnt_q;
	wire        waiting = wait_motion_finish_in | home_seek_in;
	wire        end_timeout = waiting & ~motion_done & (wait_cnt_q >= motion_end_timeout_in);
	always @(posedge sys_clk_in) begin
		if (srst_in || !waiting || motion_done)
			wait_cnt_q <= 32'h0;
		else if (wait_cnt_q != 32'hFFFFFFFF) // Saturate, never wrap past the limit
			wait_cnt_q <= wait_cnt_q + 32'h1;
	end

	// Detector vector, position order sets priority
	// Busy-qualified detectors ignore counter writes and starts made at rest
	wire [12:0] fault;
	assign fault[0]  = lim_ok[0] & lim_ok[1];
	assign fault[1]  = end_timeout;
	assign fault[2]  = pos_range_err_in;
	assign fault[3]  = stack_overflow_in;
	assign fault[4]  = seq_ref_err_in;
	assign fault[5]  = calc_overflow_in;
	assign fault[6]  = param_range_err_in;
	assign fault[7]  = zero_div_in;
	assign fault[8]  = pc_write_in & motion_busy_in;
	assign fault[9]  = var_ref_err_in;
	assign fault[10] = param_write_err_in;
	assign fault[11] = motion_start_in & motion_busy_in;
	assign fault[12] = user_alarm_cmd_in;

	// Priority pick of the lowest-index fault
	// Scanning downward lets the lowest index write last, so it wins
	reg [7:0]  new_code;
	reg        new_cur_off;
	integer    i;
	always @* begin
		new_code    = `CODE_NONE;
		new_cur_off = 1'b0;
		for (i = `SOURCE_COUNT - 1; i >= 0; i = i - 1) begin
			if (fault[i]) begin
				new_code    = code_of(i);
				new_cur_off = CURRENT_OFF_MASK[i];
			end
		end
	end

	// Latched alarm state; every listed alarm is command-clearable
	reg [7:0] code_q;
	reg       active_q;
	reg       cur_off_q;
	reg [3:0] blink_cnt_q;
	reg [7:0] code_d;
	reg       active_d;
	reg       cur_off_d;
	reg [3:0] blink_cnt_d;
	wire      any_fault = |fault;

	// A valid clear: reset command always, clear command only with no fault standing
	wire      alarm_drop = reset_cmd_in | (active_q & alarm_clear_cmd_in & ~any_fault);

	// Next alarm state: a valid clear first, then a new fault
	always @* begin
		code_d      = code_q;
		active_d    = active_q;
		cur_off_d   = cur_off_q;
		blink_cnt_d = blink_cnt_q;
		if (alarm_drop) begin
			// A fault present in a reset-command clear does not keep the alarm: clear wins
			code_d      = `CODE_NONE;
			active_d    = 1'b0;
			cur_off_d   = 1'b0;
			blink_cnt_d = 4'h0;
		end else if (!active_q && any_fault) begin
			// First code is kept; later faults cannot overwrite it
			code_d      = new_code;
			active_d    = 1'b1;
			cur_off_d   = new_cur_off;
			blink_cnt_d = blinks_of(new_code);
		end
	end

	// Alarm flip-flops; the blink count is latched so no decoder sits on the sequencer path
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			code_q      <= `CODE_NONE;
			active_q    <= 1'b0;
			cur_off_q   <= 1'b0;
			blink_cnt_q <= 4'h0;
		end else begin
			code_q      <= code_d;
			active_q    <= active_d;
			cur_off_q   <= cur_off_d;
			blink_cnt_q <= blink_cnt_d;
		end
	end

	// Status outputs follow the latched state
	assign alarm_active_out = active_q;
	assign alarm_output_out = active_q & alarm_out_assigned_in;
	assign halt_out         = active_q;
	assign current_off_out  = cur_off_q;

	// Query answer one cycle later, held as data from a flip-flop
	// Valid repeats the query one cycle late, so a one-cycle query gives a one-cycle pulse; the code stands until the next query
	always @(posedge sys_clk_in) begin
		if (srst_in) begin
			alarm_code_out       <= `CODE_NONE;
			alarm_code_valid_out <= 1'b0;
		end else begin
			alarm_code_valid_out <= alarm_code_query_in;
			if (alarm_code_query_in)
				alarm_code_out <= code_q;
		end
	end

	// Millisecond enable from a divider
	// MS_TICK must fit in 17 bits; a faster clock needs a wider divider
	reg [16:0] div_q;
	wire       ms_tick = (div_q == MS_TICK[16:0] - 17'h1);
	always @(posedge sys_clk_in) begin
		if (srst_in || ms_tick)
			div_q <= 17'h0;
		else
			div_q <= div_q + 17'h1;
	end

	// Blink sequencer: N pulses then a long gap, repeating while active
	// Restarts from the first pulse whenever a new alarm is latched
	// Phase lengths must stay below 4096 ms ticks, the width of the ms counter
	reg [2:0]  st_q;
	reg [11:0] ms_q;
	reg [3:0]  pulse_q;

	// End-of-phase decodes for the dark part of the cycle
	wire       more_pulses = (pulse_q < blink_cnt_q);
	wire       off_done    = (ms_q == BLINK_OFF[11:0] - 12'h1);
	wire       gap_done    = (ms_q == BLINK_GAP[11:0] - 12'h1);

	// Sequencer flip-flops; dark in the clear cycle so the indicator never outlives the alarm
	always @(posedge sys_clk_in) begin
		if (srst_in || !active_q || alarm_drop) begin
			st_q          <= ST_IDLE;
			ms_q          <= 12'h0;
			pulse_q       <= 4'h0;
			alarm_led_out <= 1'b0;
		end else begin
			case (st_q)
			ST_IDLE: begin
				// First pulse starts one cycle after the alarm latches
				st_q          <= ST_ON;
				ms_q          <= 12'h0;
				pulse_q       <= 4'h1;
				alarm_led_out <= 1'b1;
			end
			ST_ON: begin
				// Lit phase lasts BLINK_ON ms ticks
				if (ms_tick) begin
					if (ms_q == BLINK_ON[11:0] - 12'h1) begin
						ms_q          <= 12'h0;
						st_q          <= ST_OFF;
						alarm_led_out <= 1'b0;
					end else
						ms_q <= ms_q + 12'h1;
				end
			end
			ST_OFF: begin
				// Dark phase: short pause between pulses, long gap after the last
				if (ms_tick) begin
					// Last pulse of the group waits the long gap
					if ((more_pulses && off_done) || (!more_pulses && gap_done)) begin
						ms_q          <= 12'h0;
						st_q          <= ST_ON;
						alarm_led_out <= 1'b1;
						pulse_q       <= more_pulses ? pulse_q + 4'h1 : 4'h1;
					end else
						ms_q <= ms_q + 12'h1;
				end
			end
			default: begin
				// Illegal state: recover to idle and dark
				st_q          <= ST_IDLE;
				alarm_led_out <= 1'b0;
			end
			endcase
		end
	end
endmodule

// ### bench/alarm_handler_assertions.sv
`timescale 1ns/10ps
module alarm_handler_checker (
	input logic       sys_clk_in,
	input logic       srst_in,
	input logic       user_alarm_cmd_in,
	input logic       alarm_clear_cmd_in,
	input logic       reset_cmd_in,
	input logic       alarm_out_assigned_in,
	input logic       alarm_code_query_in,
	input logic       alarm_code_valid_out,
	input logic       alarm_active_out,
	input logic       alarm_output_out,
	input logic       alarm_led_out,
	input logic       halt_out,
	input logic       current_off_out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// Latch, hold and release of the alarm state
	user_set_a: assert property (!alarm_active_out && user_alarm_cmd_in |=> alarm_active_out)
		else $error("user alarm not latched");
	alarm_hold_a: assert property (alarm_active_out && !alarm_clear_cmd_in && !reset_cmd_in |=> alarm_active_out)
		else $error("alarm dropped without clear");
	clear_cause_a: assert property ($fell(alarm_active_out) |-> $past(alarm_clear_cmd_in) || $past(reset_cmd_in))
		else $error("alarm fell without clear");
	// Outputs that follow the alarm state
	halt_follow_a: assert property (halt_out == alarm_active_out)
		else $error("halt differs from alarm");
	output_assign_a: assert property (alarm_output_out == (alarm_active_out && alarm_out_assigned_in))
		else $error("alarm output wrong");
	current_cause_a: assert property (current_off_out |-> alarm_active_out)
		else $error("current off without alarm");
	led_quiet_a: assert property (!alarm_active_out |-> !alarm_led_out)
		else $error("indicator lit without alarm");
	// Query answers one cycle later, and only then
	query_answer_a: assert property (alarm_code_query_in |=> alarm_code_valid_out)
		else $error("query not answered");
	answer_cause_a: assert property (alarm_code_valid_out |-> $past(alarm_code_query_in))
		else $error("answer without query");
endmodule
bind motion_alarm_handler alarm_handler_checker chk (.*);

// ### bench/drive_end_model.sv
`timescale 1ns/10ps
module drive_end_model (
	input  wire logic sys_clk_in,
	input  wire logic wait_in,
	input  wire logic slow_in,
	output logic      driver_end_out = 1'b0
);
	int cnt_q = 0;
	// A slow drive never reports done, which is how the end-wait timeout is provoked
	always @(posedge sys_clk_in) begin
		cnt_q <= wait_in ? cnt_q + 1 : 0;
		driver_end_out <= wait_in && !slow_in && cnt_q >= 3;
	end
endmodule

// ### bench/motion_alarm_handler_tb_top.sv
`timescale 1ns/10ps
module motion_alarm_handler_tb_top;
	logic        sys_clk_in = 1'b0, srst_in = 1'b1, slow = 1'b0, home_seek = 1'b0;
	logic [10:0] flt = 11'h000;
	logic        motion_busy_in = 1'b1, wait_motion_finish_in = 1'b0, drive_done_select_in = 1'b1;
	logic        done_range_window_in = 1'b0, limit_pos_in = 1'b0, limit_neg_in = 1'b0;
	logic        alarm_out_assigned_in = 1'b1, alarm_clear_cmd_in = 1'b0, reset_cmd_in = 1'b0;
	logic        alarm_code_query_in = 1'b0;
	logic [31:0] motion_end_timeout_in = 32'h0000000A;
	logic [7:0]  alarm_code_out;
	logic        driver_end_in, alarm_code_valid_out, alarm_active_out, alarm_output_out;
	logic        alarm_led_out, halt_out, current_off_out;
	int          fails = 0, num_checks = 0;
	logic [7:0]  codes [0:10] = '{8'h32, 8'h90, 8'h94, 8'h98, 8'h99, 8'h9A, 8'h9D, 8'h9E,
		8'h9F, 8'hA0, 8'hE0};
	always #4 sys_clk_in = ~sys_clk_in;
	// Short ticks keep the blink pattern to a few dozen cycles
	motion_alarm_handler #(.MS_TICK(4), .BLINK_ON(2), .BLINK_OFF(2), .BLINK_GAP(5)) dut (.*,
		.pos_range_err_in(flt[0]), .stack_overflow_in(flt[1]), .seq_ref_err_in(flt[2]),
		.calc_overflow_in(flt[3]), .param_range_err_in(flt[4]), .zero_div_in(flt[5]),
		.pc_write_in(flt[6]), .var_ref_err_in(flt[7]), .param_write_err_in(flt[8]),
		.motion_start_in(flt[9]), .user_alarm_cmd_in(flt[10]), .home_seek_in(home_seek));
	drive_end_model drv (.sys_clk_in(sys_clk_in), .wait_in(wait_motion_finish_in),
		.slow_in(slow), .driver_end_out(driver_end_in));
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: %s", $time, what);
		end
	endtask
	task automatic chk1(input logic got, input logic exp, input string what);
		chk8({7'h00, got}, {7'h00, exp}, what);
	endtask
	task automatic query(input logic [7:0] exp);
		alarm_code_query_in = 1'b1;
		tick(1);
		alarm_code_query_in = 1'b0;
		chk1(alarm_code_valid_out, 1'b1, "query valid");
		chk8(alarm_code_out, exp, "alarm code");
	endtask
	// Host waits out the deceleration before clearing, else the motor may restart
	task automatic clear_alarm();
		tick(6);
		alarm_clear_cmd_in = 1'b1;
		tick(1);
		alarm_clear_cmd_in = 1'b0;
		chk1(alarm_active_out, 1'b0, "clear");
		chk1(alarm_led_out, 1'b0, "led after clear");
	endtask
	// One blink is 16 cycles; n*16 covers the last rise and ends before the next group
	task automatic blinks(input int n);
		int rises = 0;
		logic prev;
		prev = alarm_led_out;
		repeat (n * 16) begin
			tick(1);
			rises += int'(alarm_led_out && !prev);
			prev = alarm_led_out;
		end
		chk8(8'(rises), 8'(n), "blink count");
	endtask
	task automatic wait_alarm(input int n);
		for (int k = 0; k < n && alarm_active_out !== 1'b1; k++) tick(1);
		chk1(alarm_active_out, 1'b1, "alarm set");
	endtask
	task automatic end_sim();
		$display("checks %0d, mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		#(8 * 20000);
		fails++;
		end_sim();
	end
	initial begin
		tick(12);
		srst_in = 1'b0;
		for (int i = 0; i < 11; i++) begin
			flt[i] = 1'b1;
			tick(1);
			flt = 11'h000;
			chk1(alarm_active_out, 1'b1, "set");
			chk1(halt_out, 1'b1, "halt");
			chk1(alarm_output_out, 1'b1, "output");
			chk1(current_off_out, i == 10, "current");
			blinks(1);
			query(codes[i]);
			clear_alarm();
		end
		flt = 11'h401;
		alarm_out_assigned_in = 1'b0;
		tick(1);
		flt = 11'h400;
		chk1(alarm_output_out, 1'b0, "unassigned output");
		tick(1);
		query(8'h32);
		alarm_clear_cmd_in = 1'b1;
		tick(1);
		alarm_clear_cmd_in = 1'b0;
		flt = 11'h000;
		chk1(alarm_active_out, 1'b1, "clear refused");
		reset_cmd_in = 1'b1;
		tick(1);
		reset_cmd_in = 1'b0;
		alarm_out_assigned_in = 1'b1;
		chk1(alarm_active_out, 1'b0, "reset command");
		query(8'h00);
		motion_busy_in = 1'b0;
		flt[6] = 1'b1;
		flt[9] = 1'b1;
		tick(3);
		flt = 11'h000;
		chk1(alarm_active_out, 1'b0, "idle write");
		slow = 1'b1;
		wait_motion_finish_in = 1'b1;
		wait_alarm(20);
		wait_motion_finish_in = 1'b0;
		blinks(4);
		query(8'h10);
		clear_alarm();
		slow = 1'b0;
		wait_motion_finish_in = 1'b1;
		tick(20);
		chk1(alarm_active_out, 1'b0, "driver done");
		drive_done_select_in = 1'b0;
		slow = 1'b1;
		done_range_window_in = 1'b1;
		tick(20);
		chk1(alarm_active_out, 1'b0, "window done");
		done_range_window_in = 1'b0;
		wait_alarm(20);
		wait_motion_finish_in = 1'b0;
		query(8'h10);
		clear_alarm();
		home_seek = 1'b1;
		wait_alarm(20);
		home_seek = 1'b0;
		query(8'h10);
		clear_alarm();
		limit_pos_in = 1'b1;
		tick(12);
		chk1(alarm_active_out, 1'b0, "one limit");
		limit_neg_in = 1'b1;
		wait_alarm(10);
		blinks(7);
		query(8'h60);
		limit_pos_in = 1'b0;
		limit_neg_in = 1'b0;
		clear_alarm();
		flt[10] = 1'b1;
		tick(1);
		flt = 11'h000;
		chk1(alarm_active_out, 1'b1, "set before reset");
		srst_in = 1'b1;
		tick(2);
		srst_in = 1'b0;
		chk1(alarm_active_out, 1'b0, "system reset");
		chk1(current_off_out, 1'b0, "current after reset");
		chk1(alarm_led_out, 1'b0, "led after reset");
		end_sim();
	end
endmodule
